/* File: inc/asrs_pkg.sv */
package asrs_pkg;
    localparam int ACC_W   = 40;
    localparam int WORD_W  = 16;
    localparam int ADDR_W  = 16;
    localparam int PADDR_W = 12;
    localparam logic [39:0] SAT39_POS = 40'h7fffffffff;
    localparam logic [39:0] SAT39_NEG = 40'h8000000000;
    localparam logic [39:0] SAT31_POS = 40'h007fffffff;
    localparam logic [39:0] SAT31_NEG = 40'hff80000000;
    localparam logic [15:0] RND_HALF  = 16'h8000;
    localparam logic [15:0] PTR_STEP  = 16'h0002;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [1:0] SATM_OFF = 2'h0;
    localparam logic [1:0] SATM_B39 = 2'h1;
    localparam logic [1:0] SATM_B31 = 2'h2;
    // apb byte offsets
    localparam logic [11:0] OFS_CORE   = 12'h000;
    localparam logic [11:0] OFS_TRAP   = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_ACCA_L = 12'h00c;
    localparam logic [11:0] OFS_ACCA_H = 12'h010;
    localparam logic [11:0] OFS_ACCB_L = 12'h014;
    localparam logic [11:0] OFS_ACCB_H = 12'h018;
    localparam logic [11:0] OFS_WBPTR  = 12'h01c;
    localparam logic [11:0] OFS_OP     = 12'h020;
    localparam logic [11:0] OFS_MEMD   = 12'h024;
    localparam logic [11:0] OFS_PFX    = 12'h028;
    localparam logic [11:0] OFS_PFY    = 12'h02c;
    // core_control_reg fields
    localparam int CORE_RND = 0;
    localparam int CORE_SATM_LO = 1;
    // trap_control_reg fields
    localparam int TRAP_CATASTROPHIC_OVERFLOW_TRAP_EN = 0;
    // status fields
    localparam int ST_SA  = 0;
    localparam int ST_SB  = 1;
    localparam int ST_OA  = 2;
    localparam int ST_OB  = 3;
    localparam int ST_OAB = 4;
    localparam int ST_SAB = 5;
    localparam int ST_TRAP = 6;
    // op register fields
    localparam int OP_CODE_LO = 0;
    localparam int OP_TGT     = 4;
    localparam int OP_WB_LO   = 5;
    localparam int OP_ROUND   = 7;
    localparam int OP_NEG     = 8;
    localparam logic [3:0] OPC_MAC    = 4'h0;
    localparam logic [3:0] OPC_MPY    = 4'h1;
    localparam logic [3:0] OPC_MPYN   = 4'h2;
    localparam logic [3:0] OPC_ED     = 4'h3;
    localparam logic [3:0] OPC_EUCLID_DISTANCE_ACC_OP   = 4'h4;
    localparam logic [3:0] OPC_SAC    = 4'h5;
    localparam logic [3:0] OPC_SACR   = 4'h6;
    localparam logic [1:0] WB_NONE = 2'h0;
    localparam logic [1:0] WB_REG  = 2'h1;
    localparam logic [1:0] WB_IND  = 2'h2;
    // x/y space boundary and implemented top
    localparam logic [15:0] Y_BASE   = 16'h0c00;
    localparam logic [15:0] MEM_TOP  = 16'h0fff;
    localparam int MEM_WORDS = 2048;
endpackage

/* File: inc/asrs_mem_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface asrs_mem_if;
    logic        we;
    logic [10:0] waddr;
    logic [15:0] wdata;
    logic [10:0] raddr;
    logic [15:0] rdata;
    modport core (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: src/asrs_dmem.sv */
`timescale 1ns/1ns
`default_nettype none
module asrs_dmem #(
    parameter int DEPTH = asrs_pkg::MEM_WORDS
) (
    input  wire logic pclk,
    asrs_mem_if.mem   mb
);
    logic [15:0] arr [DEPTH];
    logic [15:0] rd_q;
    // the carrier fixes both addresses at 11 bits
    if (DEPTH != asrs_pkg::MEM_WORDS) begin : g_depth_chk
        $error("asrs_dmem: depth must match 11-bit address");
    end
    always_ff @(posedge pclk) begin
        if (mb.we) begin
            arr[mb.waddr] <= mb.wdata;
        end
    end
    always_ff @(posedge pclk) begin
        rd_q <= arr[mb.raddr];
    end
    assign mb.rdata = rd_q;
endmodule
`default_nettype wire

/* File: src/asrs_top.sv */
// Function
// - saturation flags update on every adder pass; hardware sets, software clears
// - with saturation off, flags record bit 39 overflow
// - trap enable plus saturation off: set flag raises catastrophic overflow trap
// - status shows OR of overflow flags and OR of saturation flags
// - bit-39 mode clamps to 9.31 extremes and sets sticky flag
// - bit-31 mode clamps to sign-extended 1.31 extremes and sets flag
// - bit-31 mode never sets overflow flags
// - catastrophic mode wraps; flag comes from bit 39 overflow
// - multiply-accumulate ops except four may store rounded other accumulator
// - write-back uses X write bus across whole data space
// - register-direct write-back puts rounded value in pointer register
// - indirect write-back stores at pointer then adds 2
// - control bit picks conventional or convergent combinational rounding
// - no rounding requested stores truncated high word
// - conventional rounding increments high word when low word >= 0x8000
// - convergent rounding at exactly 0x8000 increments only if bit 16 set
// - store ops write truncated or rounded word over X bus
// - multiply-accumulate write-back always rounds
// - X prefetch uses its own pointer register, Y uses another; Y never writes
// - unimplemented or wrong-space reads return zero
// - addresses and data paths are 16 bits, byte addressed
`timescale 1ns/1ns
`default_nettype none
module asrs_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             trap_req
);
    typedef enum logic [1:0] {ASRS_IDLE, ASRS_RD, ASRS_ANS} asrs_state_t;

    asrs_mem_if mb ();
    asrs_dmem u_mem (.pclk(pclk), .mb(mb));

    asrs_state_t st_q;
    logic [39:0] acc_a_q;
    logic [39:0] acc_b_q;
    logic        acc_a_saturated_flag_q;
    logic        acc_b_saturated_flag_q;
    logic        acc_a_overflow_flag_q;
    logic        acc_b_overflow_flag_q;
    logic [2:0]  core_control_reg_q;
    logic        trap_control_reg_q;
    logic [15:0] writeback_pointer_reg_q;
    logic [15:0] x_prefetch_ptr_a_q;
    logic [15:0] y_prefetch_ptr_a_q;
    logic [15:0] pfx_q;
    logic [15:0] pfy_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        trap_q;
    logic [1:0]  rd_kind_q;
    logic        rd_zero_q;

    wire logic wr_acc = psel && penable && pwrite && !pready_q;
    wire logic [31:0] wd = pwdata;
    wire logic [3:0] opc = wd[asrs_pkg::OP_CODE_LO +: 4];
    wire logic       tgt_b = wd[asrs_pkg::OP_TGT];
    wire logic [1:0] wbm = wd[asrs_pkg::OP_WB_LO +: 2];
    wire logic       op_go = wr_acc && (paddr == asrs_pkg::OFS_OP);
    wire logic [1:0] satm = core_control_reg_q[asrs_pkg::CORE_SATM_LO +: 2];
    wire logic       rnd_conv = core_control_reg_q[asrs_pkg::CORE_RND];
    wire logic       is_mac = (opc <= asrs_pkg::OPC_EUCLID_DISTANCE_ACC_OP);
    wire logic       is_sac = (opc == asrs_pkg::OPC_SAC) || (opc == asrs_pkg::OPC_SACR);

    // adder: operand is the word last fetched through the X prefetch window, sign-extended 1.31
    logic [39:0] tgt_acc;
    logic [39:0] addend;
    logic [40:0] sum_w;
    logic [39:0] sum;
    logic        ovf39;
    logic        ovf31;
    logic [39:0] sat_res;
    logic        sat_hit;
    always_comb begin
        tgt_acc = tgt_b ? acc_b_q : acc_a_q;
        addend  = {{8{pfx_q[15]}}, pfx_q, 16'h0000};
        if (wd[asrs_pkg::OP_NEG]) begin
            addend = 40'h0000000000 - addend;
        end
        if (opc == asrs_pkg::OPC_MPY || opc == asrs_pkg::OPC_MPYN || opc == asrs_pkg::OPC_ED) begin
            tgt_acc = 40'h0000000000;
        end
        sum_w = {tgt_acc[39], tgt_acc} + {addend[39], addend};
        sum   = sum_w[39:0];
        ovf39 = sum_w[40] ^ sum_w[39];
        ovf31 = ovf39 || (sum[39:31] != {9{sum[39]}});
        sat_res = sum;
        sat_hit = 1'b0;
        case (satm)
            asrs_pkg::SATM_B39: begin
                sat_hit = ovf39;
                if (ovf39) sat_res = sum_w[40] ? asrs_pkg::SAT39_NEG : asrs_pkg::SAT39_POS;
            end
            asrs_pkg::SATM_B31: begin
                sat_hit = ovf31;
                if (ovf31) begin
                    sat_res = (ovf39 ? sum_w[40] : sum[39]) ? asrs_pkg::SAT31_NEG
                                                           : asrs_pkg::SAT31_POS;
                end
            end
            default: begin
                sat_hit = ovf39;
                sat_res = sum;
            end
        endcase
    end
    // guard-bit overflow: result does not fit 1.31
    wire logic guard_ovf = (sat_res[39:31] != {9{sat_res[39]}});

    // round stage on the non-target (mac) or target (store) accumulator
    logic [39:0] src_acc;
    logic [15:0] hi_w;
    logic [15:0] lo_w;
    logic        inc;
    logic [15:0] st_word;
    always_comb begin
        src_acc = (is_sac ^ tgt_b) ? acc_a_q : acc_b_q;
        if (is_sac) src_acc = tgt_b ? acc_b_q : acc_a_q;
        hi_w = src_acc[31:16];
        lo_w = src_acc[15:0];
        inc = (lo_w >= asrs_pkg::RND_HALF);
        if (rnd_conv && lo_w == asrs_pkg::RND_HALF) begin
            inc = src_acc[16];
        end
        if ((opc == asrs_pkg::OPC_SAC)
            || !(wd[asrs_pkg::OP_ROUND] || is_mac || opc == asrs_pkg::OPC_SACR)) begin
            inc = 1'b0;
        end
        st_word = hi_w + {15'h0000, inc};
    end
    wire logic wb_ok = is_mac && opc != asrs_pkg::OPC_MPY && opc != asrs_pkg::OPC_MPYN
                       && opc != asrs_pkg::OPC_ED && opc != asrs_pkg::OPC_EUCLID_DISTANCE_ACC_OP;
    wire logic do_ind = op_go && ((wb_ok && wbm == asrs_pkg::WB_IND) || is_sac);

    // accumulators
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_a_q <= 40'h0000000000;
            acc_b_q <= 40'h0000000000;
        end else if (op_go && is_mac) begin
            if (tgt_b) acc_b_q <= sat_res;
            else acc_a_q <= sat_res;
        end else if (wr_acc) begin
            if (paddr == asrs_pkg::OFS_ACCA_L) acc_a_q[15:0] <= wd[15:0];
            if (paddr == asrs_pkg::OFS_ACCA_H) acc_a_q[39:16] <= wd[23:0];
            if (paddr == asrs_pkg::OFS_ACCB_L) acc_b_q[15:0] <= wd[15:0];
            if (paddr == asrs_pkg::OFS_ACCB_H) acc_b_q[39:16] <= wd[23:0];
        end
    end

    // sticky flags: set beats a simultaneous software clear
    wire logic upd_a = op_go && is_mac && !tgt_b;
    wire logic upd_b = op_go && is_mac && tgt_b;
    wire logic clr_st = wr_acc && paddr == asrs_pkg::OFS_STATUS;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_a_saturated_flag_q <= 1'b0;
            acc_b_saturated_flag_q <= 1'b0;
        end else begin
            if (upd_a && sat_hit) acc_a_saturated_flag_q <= 1'b1;
            else if (clr_st && wd[asrs_pkg::ST_SA]) acc_a_saturated_flag_q <= 1'b0;
            if (upd_b && sat_hit) acc_b_saturated_flag_q <= 1'b1;
            else if (clr_st && wd[asrs_pkg::ST_SB]) acc_b_saturated_flag_q <= 1'b0;
        end
    end
    // overflow flags follow the latest result; never set in bit-31 mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_a_overflow_flag_q <= 1'b0;
            acc_b_overflow_flag_q <= 1'b0;
        end else begin
            if (upd_a) acc_a_overflow_flag_q <= guard_ovf && satm != asrs_pkg::SATM_B31;
            if (upd_b) acc_b_overflow_flag_q <= guard_ovf && satm != asrs_pkg::SATM_B31;
        end
    end
    wire logic any_acc_overflow  = acc_a_overflow_flag_q | acc_b_overflow_flag_q;
    wire logic any_acc_saturated = acc_a_saturated_flag_q | acc_b_saturated_flag_q;
    wire logic catastrophic_overflow_trap_en = trap_control_reg_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= catastrophic_overflow_trap_en && satm == asrs_pkg::SATM_OFF
                      && any_acc_saturated;
        end
    end

    // control registers and pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_control_reg_q <= 3'h0;
            trap_control_reg_q <= 1'b0;
            writeback_pointer_reg_q <= 16'h0000;
            x_prefetch_ptr_a_q <= 16'h0000;
            y_prefetch_ptr_a_q <= 16'h0000;
        end else if (wr_acc) begin
            if (paddr == asrs_pkg::OFS_CORE) core_control_reg_q <= wd[2:0];
            if (paddr == asrs_pkg::OFS_TRAP) trap_control_reg_q <= wd[asrs_pkg::TRAP_CATASTROPHIC_OVERFLOW_TRAP_EN];
            if (paddr == asrs_pkg::OFS_PFX) x_prefetch_ptr_a_q <= wd[15:0];
            if (paddr == asrs_pkg::OFS_PFY) y_prefetch_ptr_a_q <= wd[15:0];
            if (paddr == asrs_pkg::OFS_WBPTR) begin
                writeback_pointer_reg_q <= wd[15:0];
            end else if (op_go && wb_ok && wbm == asrs_pkg::WB_REG) begin
                writeback_pointer_reg_q <= st_word;
            end else if (do_ind && !is_sac) begin
                writeback_pointer_reg_q <= writeback_pointer_reg_q + asrs_pkg::PTR_STEP;
            end
        end
    end

    // x write bus: the only write path, any data-space word
    wire logic wr_impl = writeback_pointer_reg_q <= asrs_pkg::MEM_TOP;
    assign mb.we    = do_ind && wr_impl;
    assign mb.waddr = writeback_pointer_reg_q[11:1];
    assign mb.wdata = st_word;
    wire logic mdr = psel && !penable && paddr == asrs_pkg::OFS_MEMD;
    wire logic [15:0] rd_ea = mdr ? writeback_pointer_reg_q
                            : (paddr == asrs_pkg::OFS_PFX) ? x_prefetch_ptr_a_q
                            : y_prefetch_ptr_a_q;
    assign mb.raddr = rd_ea[11:1];
    // zero returned for unimplemented or wrong-space prefetch
    wire logic rd_bad = (rd_ea > asrs_pkg::MEM_TOP)
        || (!mdr && paddr == asrs_pkg::OFS_PFX && rd_ea >= asrs_pkg::Y_BASE)
        || (!mdr && paddr != asrs_pkg::OFS_PFX && rd_ea < asrs_pkg::Y_BASE);

    // apb: every access, read or write, takes one extra cycle for the ram
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ASRS_IDLE;
            rd_kind_q <= 2'h0;
            rd_zero_q <= 1'b0;
        end else begin
            case (st_q)
                ASRS_IDLE: if (psel && !penable) begin
                    st_q <= ASRS_RD;
                    rd_zero_q <= rd_bad;
                    rd_kind_q <= (paddr == asrs_pkg::OFS_PFX) ? 2'h1
                               : (paddr == asrs_pkg::OFS_PFY) ? 2'h2 : 2'h0;
                end
                ASRS_RD:  st_q <= ASRS_ANS;
                ASRS_ANS: st_q <= ASRS_IDLE;
                default:  st_q <= ASRS_IDLE;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pfx_q <= 16'h0000;
            pfy_q <= 16'h0000;
        end else if (st_q == ASRS_RD && !pwrite) begin
            if (rd_kind_q == 2'h1) pfx_q <= rd_zero_q ? asrs_pkg::ZERO_WORD : mb.rdata;
            if (rd_kind_q == 2'h2) pfy_q <= rd_zero_q ? asrs_pkg::ZERO_WORD : mb.rdata;
        end
    end
    logic [31:0] rmux;
    logic        rerr;
    always_comb begin
        rerr = 1'b0;
        case (paddr)
            asrs_pkg::OFS_CORE:   rmux = {29'h0, core_control_reg_q};
            asrs_pkg::OFS_TRAP:   rmux = {31'h0, trap_control_reg_q};
            asrs_pkg::OFS_STATUS: rmux = {25'h0, trap_q, any_acc_saturated, any_acc_overflow,
                                          acc_b_overflow_flag_q, acc_a_overflow_flag_q,
                                          acc_b_saturated_flag_q, acc_a_saturated_flag_q};
            asrs_pkg::OFS_ACCA_L: rmux = {16'h0, acc_a_q[15:0]};
            asrs_pkg::OFS_ACCA_H: rmux = {8'h0, acc_a_q[39:16]};
            asrs_pkg::OFS_ACCB_L: rmux = {16'h0, acc_b_q[15:0]};
            asrs_pkg::OFS_ACCB_H: rmux = {8'h0, acc_b_q[39:16]};
            asrs_pkg::OFS_WBPTR:  rmux = {16'h0, writeback_pointer_reg_q};
            asrs_pkg::OFS_OP:     rmux = 32'h00000000;
            asrs_pkg::OFS_MEMD:   rmux = {16'h0, rd_zero_q ? asrs_pkg::ZERO_WORD : mb.rdata};
            asrs_pkg::OFS_PFX:    rmux = {16'h0, rd_zero_q ? asrs_pkg::ZERO_WORD : mb.rdata};
            asrs_pkg::OFS_PFY:    rmux = {16'h0, rd_zero_q ? asrs_pkg::ZERO_WORD : mb.rdata};
            default: begin
                rmux = 32'h00000000;
                rerr = 1'b1;
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= (st_q == ASRS_RD);
            pslverr_q <= (st_q == ASRS_RD) && rerr;
            prdata_q  <= (st_q == ASRS_RD && !pwrite) ? rmux : 32'h00000000;
        end
    end
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign trap_req = trap_q;

    sat_flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_a_saturated_flag_q && !clr_st |=> acc_a_saturated_flag_q)
        else $error("sat flag a dropped without clear");
    b31_no_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
        upd_a && satm == asrs_pkg::SATM_B31 |=> !acc_a_overflow_flag_q)
        else $error("overflow flag set in bit-31 mode");
    trap_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        trap_q |-> $past(trap_control_reg_q) && $past(any_acc_saturated))
        else $error("trap without cause");
    // checked at the bus output so a broken status mux is caught too
    sum_or_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && psel && !pwrite && paddr == asrs_pkg::OFS_STATUS
        |-> prdata[asrs_pkg::ST_SAB]
            == ($past(acc_a_saturated_flag_q) || $past(acc_b_saturated_flag_q)))
        else $error("summary mismatch");
    ptr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        do_ind && !is_sac
        |=> writeback_pointer_reg_q == $past(writeback_pointer_reg_q) + asrs_pkg::PTR_STEP)
        else $error("pointer not stepped by 2");
    b39_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        upd_a && satm == asrs_pkg::SATM_B39 && ovf39 && !sum_w[40]
        |=> acc_a_q == asrs_pkg::SAT39_POS)
        else $error("bit-39 clamp wrong");
    b31_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        upd_a && satm == asrs_pkg::SATM_B31 && sat_hit
        |=> acc_a_q == asrs_pkg::SAT31_POS || acc_a_q == asrs_pkg::SAT31_NEG)
        else $error("bit-31 clamp wrong");
    // an exact half always rounds to an even word in convergent mode
    rnd_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_go && (opc == asrs_pkg::OPC_SACR || wb_ok) && rnd_conv && lo_w == asrs_pkg::RND_HALF
        |-> !st_word[0])
        else $error("convergent round wrong");
endmodule
`default_nettype wire

/* File: testbench/asrs_apb_master.sv */
`timescale 1ns/1ns
`default_nettype none
module asrs_apb_master (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    int          n_hang;
    logic [31:0] rd_q;
    logic        err_q;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_hang = 0;
    end

    // entered just after a rising edge; pready, prdata and pslverr are read
    // right after each rising edge, before that edge's updates land
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (pready !== 1'b1) n_hang++;
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so psel is never lowered and raised in one step
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* File: testbench/accumulator_saturate_round_store_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module accumulator_saturate_round_store_tb_top;
    typedef struct {logic cvg; logic rnd; logic [15:0] hi; logic [15:0] lo; logic [15:0] e;} asrs_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, trap_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          n_errors = 0;
    int          cmp_count = 0;
    asrs_row_t   rows [7] = '{
        '{1'b0, 1'b1, 16'h1234, 16'h7fff, 16'h1234}, '{1'b0, 1'b1, 16'h1234, 16'h8000, 16'h1235},
        '{1'b0, 1'b1, 16'h1234, 16'hffff, 16'h1235}, '{1'b0, 1'b0, 16'h1234, 16'hffff, 16'h1234},
        '{1'b1, 1'b1, 16'h1234, 16'h8000, 16'h1234}, '{1'b1, 1'b1, 16'h1235, 16'h8000, 16'h1236},
        '{1'b1, 1'b1, 16'h1234, 16'h8001, 16'h1235}};

    always #20 pclk = ~pclk;

    asrs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trap_req(trap_req));
    asrs_apb_master apb (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic finish_test();
        n_errors += apb.n_hang;
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb.xfer(1'b1, a, d);
        if (apb.n_hang != 0) finish_test();
    endtask

    task automatic rd(input logic [11:0] a);
        apb.xfer(1'b0, a, 32'h0);
        if (apb.n_hang != 0) finish_test();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(apb.rd_q & m, e);
    endtask

    // one accumulate from zero low word; status compared under a mask
    task automatic sat_case(input logic [1:0] m, input logic b, input logic [23:0] hi,
                            input logic [23:0] ehi, input logic [15:0] elo,
                            input logic [31:0] msk, input logic [31:0] est);
        wr(asrs_pkg::OFS_STATUS, 32'h3);
        wr(asrs_pkg::OFS_CORE, {29'h0, m, 1'b0});
        wr(b ? asrs_pkg::OFS_ACCB_L : asrs_pkg::OFS_ACCA_L, 32'h0);
        wr(b ? asrs_pkg::OFS_ACCB_H : asrs_pkg::OFS_ACCA_H, {8'h0, hi});
        wr(asrs_pkg::OFS_OP, {27'h0, b, asrs_pkg::OPC_MAC});
        rd_chk(b ? asrs_pkg::OFS_ACCB_L : asrs_pkg::OFS_ACCA_L, 32'hffff, 32'(elo));
        rd_chk(b ? asrs_pkg::OFS_ACCB_H : asrs_pkg::OFS_ACCA_H, 32'hffffff, 32'(ehi));
        rd_chk(asrs_pkg::OFS_STATUS, msk, est);
        chk(32'(trap_req), 32'(est[6]));
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(asrs_pkg::OFS_STATUS, 32'hffffffff, 32'h0);
        rd_chk(12'h100, 32'hffffffff, 32'h0);
        chk(32'(apb.err_q), 32'h1);
        foreach (rows[i]) begin
            wr(asrs_pkg::OFS_CORE, 32'(rows[i].cvg));
            wr(asrs_pkg::OFS_ACCA_L, 32'(rows[i].lo));
            wr(asrs_pkg::OFS_ACCA_H, 32'(rows[i].hi));
            wr(asrs_pkg::OFS_WBPTR, 32'h100);
            wr(asrs_pkg::OFS_OP, 32'(rows[i].rnd ? asrs_pkg::OPC_SACR : asrs_pkg::OPC_SAC));
            rd_chk(asrs_pkg::OFS_MEMD, 32'hffff, 32'(rows[i].e));
        end
        // write-back always rounds even with the round bit clear
        wr(asrs_pkg::OFS_CORE, 32'h0);
        wr(asrs_pkg::OFS_ACCB_L, 32'h8000);
        wr(asrs_pkg::OFS_ACCB_H, 32'h2468);
        wr(asrs_pkg::OFS_OP, 32'h20);
        rd_chk(asrs_pkg::OFS_WBPTR, 32'hffff, 32'h2469);
        wr(asrs_pkg::OFS_WBPTR, 32'h200);
        wr(asrs_pkg::OFS_OP, 32'h40);
        rd_chk(asrs_pkg::OFS_WBPTR, 32'hffff, 32'h202);
        wr(asrs_pkg::OFS_WBPTR, 32'h200);
        rd_chk(asrs_pkg::OFS_MEMD, 32'hffff, 32'h2469);
        for (int c = 1; c <= 4; c++) begin
            wr(asrs_pkg::OFS_WBPTR, 32'h300);
            wr(asrs_pkg::OFS_OP, 32'h20 | 32'(c));
            rd_chk(asrs_pkg::OFS_WBPTR, 32'hffff, 32'h300);
        end
        // plant 0x7fff at 0x100 as the addend source
        wr(asrs_pkg::OFS_ACCA_L, 32'h0);
        wr(asrs_pkg::OFS_ACCA_H, 32'h7fff);
        wr(asrs_pkg::OFS_WBPTR, 32'h100);
        wr(asrs_pkg::OFS_OP, 32'(asrs_pkg::OPC_SAC));
        wr(asrs_pkg::OFS_PFY, 32'h100);
        rd_chk(asrs_pkg::OFS_PFY, 32'hffff, 32'h0);
        wr(asrs_pkg::OFS_PFX, 32'(asrs_pkg::Y_BASE));
        rd_chk(asrs_pkg::OFS_PFX, 32'hffff, 32'h0);
        wr(asrs_pkg::OFS_PFX, 32'h2000);
        rd_chk(asrs_pkg::OFS_PFX, 32'hffff, 32'h0);
        wr(asrs_pkg::OFS_PFX, 32'h100);
        rd_chk(asrs_pkg::OFS_PFX, 32'hffff, 32'h7fff);
        wr(asrs_pkg::OFS_TRAP, 32'h1);
        sat_case(asrs_pkg::SATM_B39, 1'b0, 24'h7fffff, 24'h7fffff, 16'hffff, 32'h63, 32'h21);
        sat_case(asrs_pkg::SATM_B31, 1'b0, 24'h007fff, 24'h007fff, 16'hffff, 32'h7f, 32'h21);
        sat_case(asrs_pkg::SATM_OFF, 1'b1, 24'h7fffff, 24'h807ffe, 16'h0000, 32'h63, 32'h62);
        wr(asrs_pkg::OFS_TRAP, 32'h0);
        chk(32'(trap_req), 32'h0);
        wr(asrs_pkg::OFS_STATUS, 32'h3);
        rd_chk(asrs_pkg::OFS_STATUS, 32'h23, 32'h0);
        wr(asrs_pkg::OFS_WBPTR, 32'h2000);
        rd_chk(asrs_pkg::OFS_MEMD, 32'hffff, 32'h0);
        // reset in mid-run: overflow flags and the high half of accumulator B return to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(asrs_pkg::OFS_STATUS, 32'hffffffff, 32'h0);
        rd_chk(asrs_pkg::OFS_ACCB_H, 32'hffffffff, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
